/* File: verilog/sac_converter.sv */
// Contract
// R01: Ten-bit successive approximation result, held readable
// R02: Four-bit field selects one of sixteen inputs
// R03: Above high reference reads FFh and 03h
// R04: Below low reference reads zero
// R05: Converter-on starts continuous conversion
// R06: Each completion loads result, sets flag
// R07: High byte read or status write clears flag
// R08: Software reads both bytes before next completion
// R09: Software polls, reads low then high
// R10: Software may read high byte only
// R11: Channel change aborts, clears flag, restarts
// R12: Clearing converter-on stops conversion
// R13: Clock select: 0 divides four, 1 two
// R14: Wait mode leaves converter running
// R15: Halt disables converter; software awaits stabilization
// R16: Software writes zero to bit four
// R17: Flag bit read-only, others read/write; bit four reads zero and ignores writes
// R18: Control/status resets to all zeros
// R19: Software configures analog pins as inputs
// R20: Channel code n selects input n
// R21: High byte holds result bits nine..two
// R22: Low byte holds bits one..zero, rest zero
// R23: Ten steps per conversion, MSB first
// R24: No interrupt; completion only by polled flag
`timescale 1ns/1ns
`include "sac_regs.svh"

module sac_converter (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output sac_pkg::sac_ana_s ana_out,
  input  wire logic        comp_above,
  input  wire logic        halt_mode
);
  import sac_pkg::*;

  // Register state
  logic       eoc_r;
  logic       eoc_nxt;
  logic       speed_r;
  logic       speed_nxt;
  logic       on_r;
  logic       on_nxt;
  localparam logic [7:0] csr_rst_v = `SAC_CSR_RST;
  logic [3:0] chan_r;
  logic [3:0] chan_nxt;
  logic [9:0] res_r;
  logic [9:0] res_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic       err_r;
  logic       err_nxt;

  // Conversion state
  sac_state_e state_r;
  sac_state_e state_nxt;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic [9:0] sar_r;
  logic [9:0] sar_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  sac_ana_s   ana_r;
  sac_ana_s   ana_nxt;

  // Bus decode
  logic       access;
  logic       setup;
  logic       csr_wr;
  logic       hi_rd;
  logic       chan_change;
  logic [9:0] idx;
  logic       run;
  logic       abort;
  logic       tick;
  logic       conv_done;
  logic [1:0] div_last;

  assign idx       = paddr[11:2];
  assign access    = psel & penable;
  assign setup     = psel & ~penable;
  assign csr_wr    = access & pwrite & (idx == `SAC_IDX_CSR);
  assign hi_rd     = access & ~pwrite & (idx == `SAC_IDX_HI);
  assign chan_change = csr_wr & (pwdata[`SAC_CHAN_MSB:`SAC_CHAN_LSB] != chan_r); // R11

  // Only halt and the converter-on bit gate the converter; wait mode has no effect here
  assign run   = on_r & ~halt_mode; // R05 R12 R14 R15
  assign abort = ~run | chan_change; // R11 R12

  assign div_last = speed_r ? `SAC_DIV2_LAST : `SAC_DIV4_LAST; // R13
  assign tick     = (div_r == div_last);

  assign conv_done = (state_r == SAC_STEP) & tick & ~abort & (bit_r == `SAC_BIT_LAST);

  // Zero wait state: read data was captured during the setup cycle
  assign pready  = access;
  assign pslverr = access & err_r;
  assign prdata  = prdata_r;
  assign ana_out = ana_r;

  // Register file next state
  always_comb begin
    speed_nxt  = speed_r;
    on_nxt     = on_r;
    chan_nxt   = chan_r;
    res_nxt    = res_r;
    eoc_nxt    = eoc_r;
    prdata_nxt = prdata_r;
    err_nxt    = err_r;
    // Flag bit and bit four ignore writes; other bits store
    if (csr_wr) begin // R17
      speed_nxt = pwdata[`SAC_CSR_SPEED];
      on_nxt    = pwdata[`SAC_CSR_ON];
      chan_nxt  = pwdata[`SAC_CHAN_MSB:`SAC_CHAN_LSB]; // R02 R20
    end
    // Results are not held back; each completion overwrites them
    if (conv_done) begin // R01 R06
      res_nxt = {sar_r[9:1], comp_above};
    end
    // Completion wins over a clear in the same cycle
    // The polled flag is the only completion signal
    if (conv_done) begin // R06 R24
      eoc_nxt = 1'b1;
    end else if (csr_wr | hi_rd) begin // R07 R11
      eoc_nxt = 1'b0;
    end
    if (setup) begin
      err_nxt = 1'b0;
      case (idx)
        `SAC_IDX_CSR: begin
          prdata_nxt = {24'h000000, eoc_r, speed_r, on_r, 1'b0, chan_r}; // R17
        end
        `SAC_IDX_HI: begin
          prdata_nxt = {24'h000000, res_r[9:2]}; // R21
        end
        `SAC_IDX_LO: begin
          prdata_nxt = {30'h00000000, res_r[1:0]}; // R22
        end
        default: begin
          prdata_nxt = 32'h00000000;
          err_nxt    = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin // R18
      eoc_r    <= csr_rst_v[`SAC_CSR_EOC];
      speed_r  <= csr_rst_v[`SAC_CSR_SPEED];
      on_r     <= csr_rst_v[`SAC_CSR_ON];
      chan_r   <= csr_rst_v[`SAC_CHAN_MSB:`SAC_CHAN_LSB];
      res_r    <= `SAC_RES_RST;
      prdata_r <= 32'h00000000;
      err_r    <= 1'b0;
    end else begin
      eoc_r    <= eoc_nxt;
      speed_r  <= speed_nxt;
      on_r     <= on_nxt;
      chan_r   <= chan_nxt;
      res_r    <= res_nxt;
      prdata_r <= prdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // Conversion sequencer next state
  always_comb begin
    state_nxt = state_r;
    sar_nxt   = sar_r;
    bit_nxt   = bit_r;
    div_nxt   = (abort | tick) ? 2'h0 : div_r + 2'h1;
    if (!run) begin // R12 R15
      state_nxt = SAC_IDLE;
      sar_nxt   = 10'h000;
      bit_nxt   = `SAC_BIT_FIRST;
    end else if (chan_change) begin // R11
      state_nxt = SAC_SAMPLE;
      sar_nxt   = 10'h000;
      bit_nxt   = `SAC_BIT_FIRST;
    end else begin
      case (state_r)
        SAC_IDLE: begin
          state_nxt = SAC_SAMPLE; // R05
        end
        SAC_SAMPLE: begin
          if (tick) begin // R23
            state_nxt = SAC_STEP;
            sar_nxt   = 10'h000;
            bit_nxt   = `SAC_BIT_FIRST;
          end
        end
        SAC_STEP: begin
          if (tick) begin
            // A comparator stuck high or low saturates the code
            sar_nxt[bit_r] = comp_above; // R03 R04 R23
            if (bit_r == `SAC_BIT_LAST) begin
              state_nxt = SAC_SAMPLE; // R05
            end else begin
              bit_nxt = bit_r - 4'h1;
            end
          end
        end
        default: begin
          state_nxt = SAC_IDLE;
        end
      endcase
    end
    ana_nxt.enable  = run;
    ana_nxt.channel = chan_nxt;
    ana_nxt.sample  = (state_nxt == SAC_SAMPLE);
    ana_nxt.trial   = (state_nxt == SAC_STEP) ? (sar_nxt | (10'h001 << bit_nxt)) : sar_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= SAC_IDLE;
      div_r   <= 2'h0;
      sar_r   <= 10'h000;
      bit_r   <= `SAC_BIT_FIRST;
      ana_r   <= '0;
    end else begin
      state_r <= state_nxt;
      div_r   <= div_nxt;
      sar_r   <= sar_nxt;
      bit_r   <= bit_nxt;
      ana_r   <= ana_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_eoc_on_done: assert property ( // R06
    conv_done |=> eoc_r && res_r[0] == $past(comp_above)
  ) else $error("flag or result not loaded at completion");

  chk_result_bits: assert property ( // R01
    conv_done |=> res_r[9:1] == $past(sar_r[9:1])
  ) else $error("result upper bits differ from approximation");

  chk_hi_read_clear: assert property ( // R07
    hi_rd && !conv_done |=> !eoc_r
  ) else $error("high byte read did not clear flag");

  chk_csr_wr_clear: assert property ( // R07
    csr_wr && !conv_done |=> !eoc_r
  ) else $error("status write did not clear flag");

  chk_chan_abort: assert property ( // R11
    chan_change && run |=> state_r == SAC_SAMPLE && ana_out.channel == $past(pwdata[3:0])
  ) else $error("channel change did not restart conversion");

  chk_off_stops: assert property ( // R12
    !run |=> state_r == SAC_IDLE && !ana_out.enable && !conv_done
  ) else $error("converter still running while off or halted");

  chk_div_two: assert property ( // R13
    speed_r && tick && run && !abort && !csr_wr
      |=> !tick ##1 (tick || $past(abort) || $past(csr_wr))
  ) else $error("divide by two tick spacing wrong");

  chk_first_step: assert property ( // R23
    state_r == SAC_SAMPLE && tick && !abort
      |=> state_r == SAC_STEP && bit_r == 4'h9 && ana_out.trial == 10'h200
  ) else $error("conversion did not start at most significant bit");

  chk_lo_upper_zero: assert property ( // R22
    setup && idx == `SAC_IDX_LO |=> prdata[31:2] == 30'h00000000
  ) else $error("low byte upper bits not zero");

  chk_done_in_step: assert property ( // R23
    conv_done |-> $past(state_r == SAC_STEP) && bit_r == 4'h0
  ) else $error("completion outside last step");

  chk_res_hold: assert property ( // R01
    !conv_done |=> $stable(res_r)
  ) else $error("result changed without a completion");

  chk_eoc_rise: assert property ( // R06
    $rose(eoc_r) |-> $past(conv_done)
  ) else $error("flag set without a completion");

  chk_csr_rsvd_zero: assert property ( // R17
    setup && idx == `SAC_IDX_CSR |=> prdata[31:8] == 24'h000000 && !prdata[4]
  ) else $error("status reserved bits not zero");

  chk_hi_byte_map: assert property ( // R21
    setup && idx == `SAC_IDX_HI |=> prdata[7:0] == $past(res_r[9:2]) && prdata[31:8] == 24'h000000
  ) else $error("high byte does not hold result bits nine to two");

  chk_lo_byte_map: assert property ( // R22
    setup && idx == `SAC_IDX_LO |=> prdata[1:0] == $past(res_r[1:0])
  ) else $error("low byte does not hold result bits one to zero");

  chk_halt_off: assert property ( // R15
    halt_mode |=> !ana_out.enable
  ) else $error("converter enabled during halt");

endmodule // sac_converter

/* File: verilog/sac_regs.svh */
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// Register indices; byte address is four times the index
`define SAC_IDX_CSR    10'h070
`define SAC_IDX_HI     10'h071
`define SAC_IDX_LO     10'h072
// Control/status fields
`define SAC_CSR_EOC    7
`define SAC_CSR_SPEED  6
`define SAC_CSR_ON     5
`define SAC_CHAN_MSB   3
`define SAC_CHAN_LSB   0
`define SAC_CSR_RST    8'h00
`define SAC_RES_RST    10'h000
// Converter clock tick: last divider count for /4 and /2
`define SAC_DIV4_LAST  2'h3
`define SAC_DIV2_LAST  2'h1
// First and last approximation bit
`define SAC_BIT_FIRST  4'h9
`define SAC_BIT_LAST   4'h0
`endif

/* File: verilog/sac_pkg.sv */
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_STEP   = 2'b10
  } sac_state_e;

  // Drive toward the analog multiplexer and comparator
  typedef struct packed {
    logic       enable;
    logic [3:0] channel;
    logic       sample;
    logic [9:0] trial;
  } sac_ana_s;
endpackage

/* File: bench/sac_analog_model.sv */
`timescale 1ns/1ns

module sac_analog_model (
  input  wire sac_pkg::sac_ana_s ana_in,
  output logic                   comp_above
);
  import sac_pkg::*;

  // Input level per channel in result steps; beyond 0..1023 means past a reference
  int lvl [16];

  // Ideal comparator: high when the selected input reaches the trial code
  always_comb begin
    comp_above = ana_in.enable && (lvl[ana_in.channel] >= int'(ana_in.trial));
  end
endmodule // sac_analog_model

/* File: bench/sar_converter_control_tb.sv */
`timescale 1ns/1ns
`include "sac_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module sar_converter_control_tb;
  import sac_pkg::*;
  localparam logic [11:0] A_CSR = {`SAC_IDX_CSR, 2'b00};
  localparam logic [11:0] A_HI  = {`SAC_IDX_HI, 2'b00};
  localparam logic [11:0] A_LO  = {`SAC_IDX_LO, 2'b00};
  logic        ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, halt_mode = 0;
  logic        pready, pslverr, comp_above, serr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  sac_ana_s    ana;
  int          num_errors = 0, tests_run = 0, exp_v;
  integer      seed = 32'h07757c60;

  always #4 ref_clk = ~ref_clk;

  sac_converter uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ana_out(ana), .comp_above(comp_above), .halt_mode(halt_mode));
  sac_analog_model pm (.ana_in(ana), .comp_above(comp_above));

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task poll;
    int k;
    k = 0;
    do begin apb(0, A_CSR, 0); k++; end while (rd[7] !== 1'b1 && k < 100);
    `CHK("flag_set", 1'b1, rd[7])
  endtask

  // Expected code: saturates at both references
  function int conv(int l);
    return l > 1023 ? 1023 : (l < 0 ? 0 : l);
  endfunction

  task results;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    results();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    apb(0, A_CSR, 0); `CHK("csr_rst", 32'h0, rd)
    apb(0, A_HI, 0); `CHK("hi_rst", 32'h0, rd)
    apb(0, A_LO, 0); `CHK("lo_rst", 32'h0, rd)
    apb(0, 12'h3f0, 0); `CHK("unmapped", 1'b1, serr)
    $display("test reset done");
    for (int i = 0; i < 16; i++) pm.lvl[i] = $random(seed) % 1400 - 200;
    pm.lvl[0] = 5000;
    pm.lvl[1] = -9;
    apb(1, A_CSR, 32'h20);
    for (int i = 0; i < 16; i++) begin
      poll();
      exp_v = ((i % 2) << 6) | 32'h20 | i;
      // Flag bit set on purpose and must be ignored; reserved bit kept zero
      apb(1, A_CSR, exp_v | 32'h80);
      apb(0, A_CSR, 0); `CHK("csr_wr", exp_v, rd)
      poll();
      apb(0, A_LO, 0); `CHK("lo", conv(pm.lvl[i]) % 4, rd)
      apb(0, A_HI, 0); `CHK("hi", conv(pm.lvl[i]) / 4, rd)
      apb(1, A_HI, 32'hff);
      apb(0, A_CSR, 0); `CHK("flag_clr", exp_v, rd)
      apb(0, A_HI, 0); `CHK("hi_ro", conv(pm.lvl[i]) / 4, rd)
    end
    $display("test channels done");
    apb(1, A_CSR, 32'h0);
    repeat (100) @(posedge ref_clk);
    apb(0, A_CSR, 0); `CHK("off", 32'h0, rd)
    `CHK("en_off", 1'b0, ana.enable)
    apb(1, A_CSR, 32'h65);
    halt_mode <= 1'b1;
    repeat (100) @(posedge ref_clk);
    `CHK("en_halt", 1'b0, ana.enable)
    `CHK("smp_halt", 1'b0, ana.sample)
    apb(0, A_CSR, 0); `CHK("csr_halt", 32'h65, rd)
    halt_mode <= 1'b0;
    // Let the analog side settle after wakeup before trusting a result
    repeat (20) @(posedge ref_clk);
    poll();
    apb(0, A_LO, 0); `CHK("lo_wake", conv(pm.lvl[5]) % 4, rd)
    apb(0, A_HI, 0); `CHK("hi_wake", conv(pm.lvl[5]) / 4, rd)
    $display("test power done");
    results();
  end
endmodule // sar_converter_control_tb
